// [src/mbrs_pkg.sv]
package mbrs_pkg;
	// ***********************************************
	// clock and link defaults
	// ***********************************************
	localparam int unsigned CLK_HZ = 50000000;
	localparam int unsigned DEF_BAUD = 19200;
	localparam logic [7:0] DEF_ADDR = 8'h7e;
	localparam logic [7:0] DEF_DELAY = 8'h00;
	localparam int unsigned STOP_BITS = 2;
	localparam int unsigned DATA_BITS = 8;
	localparam int unsigned MS_CYC = CLK_HZ / 1000;
	localparam logic [15:0] DEF_DIV = 16'(CLK_HZ / DEF_BAUD);
	// ***********************************************
	// register offsets
	// ***********************************************
	localparam logic [7:0] OFS_ADDR = 8'h00;
	localparam logic [7:0] OFS_DIV = 8'h04;
	localparam logic [7:0] OFS_DELAY = 8'h08;
	localparam logic [7:0] OFS_CTRL = 8'h0c;
	localparam logic [7:0] OFS_STAT = 8'h10;
	localparam logic [7:0] OFS_RXD = 8'h14;
	localparam logic [7:0] OFS_TXD = 8'h18;
	localparam logic [7:0] OFS_DOUT = 8'h1c;
	// ctrl bits
	localparam int unsigned CTRL_UNLOCK = 0;
	localparam int unsigned CTRL_REMOTE = 1;
	localparam int unsigned CTRL_FWEN = 2;
	localparam logic [2:0] CTRL_RST = 3'h0;
	typedef enum logic [1:0] {
		MBRS_TX_IDLE = 2'b00,
		MBRS_TX_WAIT = 2'b01,
		MBRS_TX_SEND = 2'b10
	} mbrs_tx_t;
endpackage : mbrs_pkg

// [src/mbrs_cfg_if.sv]
`timescale 1ns/1ps
interface mbrs_cfg_if;
	logic [15:0] div;
	logic [7:0] delay;
	logic [7:0] tx_data;
	logic tx_go;
	logic tx_busy;
	modport ctl (output div, delay, tx_data, tx_go, input tx_busy);
	modport tx (input div, delay, tx_data, tx_go, output tx_busy);
endinterface : mbrs_cfg_if

// [src/mbrs_tx.sv]
`timescale 1ns/1ps
module mbrs_tx
	import mbrs_pkg::*;
(
	// clock, reset
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic clk_en,
	// config and data
	mbrs_cfg_if.tx cfg,
	// line
	output logic txd,
	output logic tx_oe
);
	import mbrs_pkg::*;
	mbrs_tx_t st_reg;
	logic [31:0] cnt_reg;
	logic [3:0] bit_reg;
	logic [10:0] sh_reg;
	logic [31:0] wait_cyc;
	// ***********************************************
	// reply delay then frame shift
	// ***********************************************
	// auto delay: 38 bit times, 3.5 characters of 11 bits rounded down
	always_comb begin
		if (cfg.delay == 8'h00)
			wait_cyc = 32'(cfg.div) * 32'd38 + 32'd1;
		else
			wait_cyc = 32'(cfg.delay) * 32'(MS_CYC);
	end
	assign cfg.tx_busy = (st_reg != MBRS_TX_IDLE);
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_reg <= MBRS_TX_IDLE;
			cnt_reg <= 32'h0;
			bit_reg <= 4'h0;
			sh_reg <= 11'h7ff;
			txd <= 1'b1;
			tx_oe <= 1'b0;
		end else if (clk_en) begin
			case (st_reg)
				MBRS_TX_IDLE: begin
					txd <= 1'b1;
					tx_oe <= 1'b0;
					if (cfg.tx_go) begin
						// start, 8 data lsb first, 2 stop
						sh_reg <= {2'b11, cfg.tx_data, 1'b0};
						cnt_reg <= wait_cyc;
						st_reg <= MBRS_TX_WAIT;
					end
				end
				MBRS_TX_WAIT: begin
					if (cnt_reg <= 32'd1) begin
						cnt_reg <= 32'(cfg.div);
						bit_reg <= 4'd11;
						tx_oe <= 1'b1;
						txd <= sh_reg[0];
						sh_reg <= {1'b1, sh_reg[10:1]};
						st_reg <= MBRS_TX_SEND;
					end else
						cnt_reg <= cnt_reg - 32'd1;
				end
				MBRS_TX_SEND: begin
					if (cnt_reg <= 32'd1) begin
						cnt_reg <= 32'(cfg.div);
						if (bit_reg == 4'd1) begin
							st_reg <= MBRS_TX_IDLE;
							tx_oe <= 1'b0;
							txd <= 1'b1;
						end else begin
							bit_reg <= bit_reg - 4'd1;
							txd <= sh_reg[0];
							sh_reg <= {1'b1, sh_reg[10:1]};
						end
					end else
						cnt_reg <= cnt_reg - 32'd1;
				end
				default: st_reg <= MBRS_TX_IDLE;
			endcase
		end
	end
endmodule : mbrs_tx

// [src/mbrs_link.sv]
`timescale 1ns/1ps
// Function
// - only replies, never starts a transfer
// - default address 126, 19200 baud, 8N2
// - delay zero derives delay from baud
// - manual delay 1 to 255 ms
// - settings from menu or link
// - settings read/write
// - firmware bytes accepted from link
// - protected writes refused unless unlocked
// - remote output set by link command
module mbrs_link
	import mbrs_pkg::*;
(
	// clock, reset
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic clk_en,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// local menu
	input wire logic menu_we,
	input wire logic [1:0] menu_sel,
	input wire logic [15:0] menu_val,
	// rs485 line
	input wire logic rxd,
	output logic txd,
	output logic tx_oe,
	// digital output
	output logic dout
);
	import mbrs_pkg::*;
	mbrs_cfg_if cfg ();
	logic [7:0] addr_reg;
	logic [15:0] div_reg;
	logic [7:0] delay_reg;
	logic [2:0] ctrl_reg;
	logic [7:0] rxd_reg;
	logic rx_valid_reg;
	logic rx_ovr_reg;
	logic [7:0] txd_reg;
	logic go_reg;
	logic dout_reg;
	logic fw_byte_reg;
	logic [2:0] rsync_reg;
	logic [15:0] rcnt_reg;
	logic [3:0] rbit_reg;
	logic [7:0] rsh_reg;
	logic rbusy_reg;
	logic wr, rd, prot, rx_done, rline;
	logic rsh_line;
	// ***********************************************
	// apb decode
	// ***********************************************
	function automatic logic is_prot(input logic [7:0] a);
		is_prot = (a == OFS_ADDR) || (a == OFS_DIV) || (a == OFS_DELAY) ||
			(a == OFS_DOUT);
	endfunction : is_prot
	assign pready = 1'b1;
	assign wr = psel && penable && pwrite && clk_en;
	assign rd = psel && penable && !pwrite && clk_en;
	assign prot = is_prot(paddr) && !ctrl_reg[CTRL_UNLOCK];
	assign pslverr = psel && penable && pwrite && prot;
	// ***********************************************
	// link configuration
	// ***********************************************
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			addr_reg <= DEF_ADDR;
			div_reg <= DEF_DIV;
			delay_reg <= DEF_DELAY;
		end else if (clk_en) begin
			if (wr && !prot) begin
				if (paddr == OFS_ADDR)
					addr_reg <= pwdata[7:0];
				if (paddr == OFS_DIV && pwdata[15:0] != 16'h0)
					div_reg <= pwdata[15:0];
				if (paddr == OFS_DELAY)
					delay_reg <= pwdata[7:0];
			end else if (menu_we) begin
				case (menu_sel)
					2'h0: addr_reg <= menu_val[7:0];
					2'h1: if (menu_val != 16'h0) div_reg <= menu_val;
					2'h2: delay_reg <= menu_val[7:0];
					default: ;
				endcase
			end
		end
	end
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_reg <= CTRL_RST;
			dout_reg <= 1'b0;
		end else if (clk_en && wr) begin
			if (paddr == OFS_CTRL)
				ctrl_reg <= pwdata[2:0];
			if (paddr == OFS_DOUT && !prot && ctrl_reg[CTRL_REMOTE])
				dout_reg <= pwdata[0];
		end
	end
	assign dout = dout_reg;
	// ***********************************************
	// reply byte, sent only after a request
	// ***********************************************
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			txd_reg <= 8'h0;
			go_reg <= 1'b0;
		end else if (clk_en) begin
			go_reg <= 1'b0;
			if (wr && paddr == OFS_TXD && !cfg.tx_busy && !go_reg) begin
				txd_reg <= pwdata[7:0];
				go_reg <= 1'b1;
			end
		end
	end
	assign cfg.div = div_reg;
	assign cfg.delay = delay_reg;
	assign cfg.tx_data = txd_reg;
	assign cfg.tx_go = go_reg;
	mbrs_tx u_tx (
		.core_clk(core_clk),
		.arst_n(arst_n),
		.clk_en(clk_en),
		.cfg(cfg),
		.txd(txd),
		.tx_oe(tx_oe)
	);
	// ***********************************************
	// receiver
	// ***********************************************
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n)
			rsync_reg <= 3'h7;
		else if (clk_en)
			rsync_reg <= {rsync_reg[1:0], rxd};
	end
	assign rline = (rsync_reg[1] == rsync_reg[2]) ? rsync_reg[2] : rsh_line;
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n)
			rsh_line <= 1'b1;
		else if (clk_en)
			rsh_line <= rline;
	end
	assign rx_done = rbusy_reg && rcnt_reg == 16'h0 && rbit_reg == 4'd9;
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rbusy_reg <= 1'b0;
			rcnt_reg <= 16'h0;
			rbit_reg <= 4'h0;
			rsh_reg <= 8'h0;
		end else if (clk_en) begin
			if (!rbusy_reg) begin
				if (!rline) begin
					rbusy_reg <= 1'b1;
					rcnt_reg <= {1'b0, div_reg[15:1]};
					rbit_reg <= 4'h0;
				end
			end else if (rcnt_reg != 16'h0)
				rcnt_reg <= rcnt_reg - 16'h1;
			else begin
				rcnt_reg <= div_reg - 16'h1;
				rbit_reg <= rbit_reg + 4'h1;
				if (rbit_reg == 4'h0 && rline)
					rbusy_reg <= 1'b0;
				else if (rbit_reg >= 4'h1 && rbit_reg <= 4'h8)
					rsh_reg <= {rline, rsh_reg[7:1]};
				else if (rbit_reg == 4'd9)
					rbusy_reg <= 1'b0;
			end
		end
	end
	// received byte for software; firmware bytes flagged
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rxd_reg <= 8'h0;
			rx_valid_reg <= 1'b0;
			rx_ovr_reg <= 1'b0;
			fw_byte_reg <= 1'b0;
		end else if (clk_en) begin
			if (rx_done && rline) begin
				rxd_reg <= rsh_reg;
				rx_valid_reg <= 1'b1;
				rx_ovr_reg <= rx_ovr_reg | rx_valid_reg;
				fw_byte_reg <= ctrl_reg[CTRL_FWEN] && ctrl_reg[CTRL_UNLOCK];
			end else if (rd && paddr == OFS_RXD) begin
				rx_valid_reg <= 1'b0;
				rx_ovr_reg <= 1'b0;
			end
		end
	end
	// ***********************************************
	// read mux
	// ***********************************************
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n)
			prdata <= 32'h0;
		else if (clk_en && psel && !penable && !pwrite) begin
			case (paddr)
				OFS_ADDR: prdata <= {24'h0, addr_reg};
				OFS_DIV: prdata <= {16'h0, div_reg};
				OFS_DELAY: prdata <= {24'h0, delay_reg};
				OFS_CTRL: prdata <= {29'h0, ctrl_reg};
				OFS_STAT: prdata <= {28'h0, fw_byte_reg, cfg.tx_busy,
					rx_ovr_reg, rx_valid_reg};
				OFS_RXD: prdata <= {24'h0, rxd_reg};
				OFS_DOUT: prdata <= {31'h0, dout_reg};
				default: prdata <= 32'h0;
			endcase
		end
	end
endmodule : mbrs_link

// [bench/mbrs_link_monitor.sv]
`timescale 1ns/1ps
module mbrs_link_monitor
	import mbrs_pkg::*;
(
	// clock, reset
	input wire logic core_clk,
	input wire logic arst_n,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	// line, output
	input wire logic txd,
	input wire logic tx_oe,
	input wire logic dout
);
	// ***********************************************
	// helper state
	// ***********************************************
	logic unl_reg;
	logic req_reg;
	wire wr = psel && penable && pwrite;
	wire prot = paddr == OFS_ADDR || paddr == OFS_DIV
		|| paddr == OFS_DELAY || paddr == OFS_DOUT;
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			unl_reg <= 1'b0;
			req_reg <= 1'b0;
		end else begin
			if (wr && paddr == OFS_CTRL)
				unl_reg <= pwdata[CTRL_UNLOCK];
			if (tx_oe)
				req_reg <= 1'b0;
			if (wr && paddr == OFS_TXD)
				req_reg <= 1'b1;
		end
	end
	// ***********************************************
	// properties
	// ***********************************************
	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	a_ready_high: assert property (pready)
		else $error("pready low");
	a_err_locked: assert property (pslverr == (wr && !unl_reg && prot))
		else $error("pslverr wrong");
	a_idle_high: assert property (!tx_oe |-> txd)
		else $error("txd low while idle");
	a_start_low: assert property ($rose(tx_oe) |-> !txd)
		else $error("no start bit");
	a_frame_hold: assert property ($rose(tx_oe) |-> tx_oe[*8])
		else $error("frame cut short");
	a_stop_high: assert property ($fell(tx_oe) |-> $past(txd))
		else $error("stop bit low");
	a_reply_only: assert property ($rose(tx_oe) |-> req_reg)
		else $error("unrequested frame");
	a_dout_cmd: assert property ($changed(dout) |->
		$past(wr && paddr == OFS_DOUT))
		else $error("dout moved alone");
	c_frame: cover property ($rose(tx_oe));
	c_refused: cover property (pslverr);
	c_dout: cover property ($rose(dout));
endmodule : mbrs_link_monitor
bind mbrs_link mbrs_link_monitor i_mbrs_link_monitor (.core_clk, .arst_n,
	.psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .txd,
	.tx_oe, .dout);

// [bench/mbrs_master.sv]
`timescale 1ns/1ps
module mbrs_master #(
	parameter int BIT_CYC = 8
) (
	// clock
	input wire logic core_clk,
	// line
	input wire logic txd,
	input wire logic tx_oe,
	output logic rxd
);
	// ***********************************************
	// frame send and capture
	// ***********************************************
	logic [7:0] got;
	logic stop_ok;
	int got_n = 0;
	initial rxd = 1'b1;
	task send_byte(input logic [7:0] b);
		logic [10:0] f;
		f = {2'b11, b, 1'b0};
		for (int i = 0; i < 11; i++) begin
			rxd <= f[i];
			repeat (BIT_CYC) @(posedge core_clk);
		end
	endtask : send_byte
	always begin
		do @(posedge core_clk); while (!(tx_oe === 1'b1 && txd === 1'b0));
		repeat (BIT_CYC / 2) @(posedge core_clk);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT_CYC) @(posedge core_clk);
			got[i] = txd;
		end
		stop_ok = 1'b1;
		for (int i = 0; i < 2; i++) begin
			repeat (BIT_CYC) @(posedge core_clk);
			stop_ok = stop_ok & txd;
		end
		got_n++;
	end
endmodule : mbrs_master

// [bench/mbrs_link_tb.sv]
`timescale 1ns/1ps
module mbrs_link_tb;
	import mbrs_pkg::*;
	// ***********************************************
	// signals and instances
	// ***********************************************
	logic core_clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic clk_en = 1;
	logic menu_we = 0, pready, pslverr, rxd, txd, tx_oe, dout, er;
	logic [7:0] paddr = 0;
	logic [1:0] menu_sel = 0;
	logic [15:0] menu_val = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	int err_count = 0, checks_done = 0, n;
	initial forever #10 core_clk = ~core_clk;
	mbrs_link i_mbrs_link (.core_clk, .arst_n, .clk_en, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.menu_we, .menu_sel, .menu_val, .rxd, .txd, .tx_oe, .dout);
	mbrs_master #(.BIT_CYC(8)) i_mbrs_master (.core_clk, .txd, .tx_oe, .rxd);
	task final_report;
		if (err_count == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : final_report
	task chk(input string s, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			err_count++;
			$display("BAD %s exp %h got %h", s, e, g);
		end
	endtask : chk
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1;
		@(posedge core_clk);
		while (pready !== 1'b1) @(posedge core_clk);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask : apb
	task menu(input logic [1:0] s, input logic [15:0] v);
		@(posedge core_clk);
		menu_we <= 1;
		menu_sel <= s;
		menu_val <= v;
		@(posedge core_clk);
		menu_we <= 0;
	endtask : menu
	task tx_byte(input logic [7:0] b, input int lo);
		int k;
		k = i_mbrs_master.got_n;
		apb(1, OFS_TXD, {24'h0, b});
		n = 0;
		while (tx_oe !== 1'b1 && n < 60000) begin
			@(posedge core_clk);
			n++;
		end
		chk("delay", 1, 32'(n >= lo - 2 && n <= lo + 3));
		wait (i_mbrs_master.got_n != k);
		chk("txbyte", {24'h0, b}, {24'h0, i_mbrs_master.got});
		chk("stop", 1, 32'(i_mbrs_master.stop_ok));
	endtask : tx_byte
	// ***********************************************
	// scenarios
	// ***********************************************
	task t_defaults;
		apb(0, OFS_ADDR, 0);
		chk("addr", {24'h0, DEF_ADDR}, rd);
		apb(0, OFS_DIV, 0);
		chk("div", {16'h0, DEF_DIV}, rd);
		apb(0, OFS_DELAY, 0);
		chk("delay", 32'h0, rd);
		apb(1, OFS_ADDR, 32'h11);
		chk("err", 1, 32'(er));
		apb(0, OFS_ADDR, 0);
		chk("addr", {24'h0, DEF_ADDR}, rd);
	endtask : t_defaults
	task t_config;
		apb(1, OFS_CTRL, 32'h3);
		apb(1, OFS_ADDR, 32'h21);
		chk("err", 0, 32'(er));
		apb(0, OFS_ADDR, 0);
		chk("addr", 32'h21, rd);
		clk_en <= 0;
		apb(1, OFS_ADDR, 32'h44);
		clk_en <= 1;
		apb(0, OFS_ADDR, 0);
		chk("frozen", 32'h21, rd);
		apb(1, OFS_DELAY, 32'hff);
		apb(0, OFS_DELAY, 0);
		chk("delay", 32'hff, rd);
		apb(1, OFS_DIV, 8);
		menu(2'h0, 16'h30);
		apb(0, OFS_ADDR, 0);
		chk("menu", 32'h30, rd);
		menu(2'h2, 16'h05);
		menu(2'h1, 16'h0);
		apb(0, OFS_DELAY, 0);
		chk("menudly", 32'h05, rd);
		apb(0, OFS_DIV, 0);
		chk("menudiv", 32'h8, rd);
		apb(1, OFS_DELAY, 0);
		apb(0, 8'h20, 0);
		chk("unmapped", 0, rd);
	endtask : t_config
	task t_link;
		tx_byte(8'ha5, 8 * 38 + 1);
		apb(1, OFS_CTRL, 32'h7);
		i_mbrs_master.send_byte(8'h3c);
		repeat (20) @(posedge core_clk);
		apb(0, OFS_STAT, 0);
		chk("stat", 32'h9, rd);
		apb(0, OFS_RXD, 0);
		chk("rxd", 32'h3c, rd);
	endtask : t_link
	task t_dout;
		apb(1, OFS_DOUT, 1);
		@(posedge core_clk);
		chk("dout", 1, 32'(dout));
		apb(1, OFS_CTRL, 32'h1);
		apb(1, OFS_DOUT, 0);
		@(posedge core_clk);
		chk("dout", 1, 32'(dout));
		apb(1, OFS_DELAY, 1);
		tx_byte(8'h5a, 50000);
	endtask : t_dout
	initial begin
		#(20 * 80000);
		err_count++;
		final_report();
	end
	initial begin
		repeat (4) @(posedge core_clk);
		arst_n <= 1;
		t_defaults();
		t_config();
		t_link();
		t_dout();
		final_report();
	end
endmodule : mbrs_link_tb
